// [uip_params.svh]
// Purpose: constants of the uart interrupt prioritizer
// Assumes: included by its bare name from the top only
// Notes:   offsets are word indices on the plain register port
// Function
// - fifos on and enables 3:0 clear gives polled mode via line status
// - line status bits: data, overrun, char errors, thr empty, all empty
// - rx ready: holding full without fifo, fifo at trigger with fifo
// - tx ready on holding empty or below trigger, also when enabled
// - line status on overrun, char error at head or at fifo entry
// - modem status interrupt when any of modem delta bits 0-3 set
// - enable bits 7:4 writable and active only with enhanced enable
// - rts low to high raises interrupt under auto rts and enable
// - cts low to high raises interrupt under auto cts and enable
// - time-out when timer of four chars plus twelve bits expires
// - xon, xoff, special match raises interrupt, status bit 4
// - wake-up interrupt on leaving sleep, cleared by status read
// - gpio interrupt on enabled asserted input, cleared by level read
// - clearing of line, rx ready, time-out, tx ready, modem sources
// - clearing of xon, xoff, special, rts and cts change sources
// - status 5:0 encodes highest pending source, levels 1 to 7
// - status bit 0 high when nothing pending, also for wake-up
// - status read reports only the top source, others stay queued
// - status bit 5 reports rts or cts change, enhanced only
// - bit 7 is fifo enable, bit 6 differs from it on gpio interrupt
`ifndef UIP_PARAMS_SVH
`define UIP_PARAMS_SVH
`define UIP_OFS_IER      4'h1
`define UIP_OFS_ISR      4'h2
`define UIP_OFS_CTRL     4'h3
`define UIP_OFS_LINE     4'h5
`define UIP_OFS_MODEM    4'h6
`define UIP_OFS_GPOL     4'h7
`define UIP_OFS_GEN      4'h8
`define UIP_RST_BYTE     8'h00
`define UIP_CTRL_FIFO    0
`define UIP_CTRL_EFR     1
`define UIP_CTRL_ARTS    2
`define UIP_CTRL_ACTS    3
`define UIP_CTRL_ERRIN   4
`define UIP_CTRL_WAKE    5
`define UIP_CODE_LINE    6'h06
`define UIP_CODE_TOUT    6'h0C
`define UIP_CODE_RECEIVE_READY_SOURCE   6'h04
`define UIP_CODE_TRANSMIT_READY_SOURCE   6'h02
`define UIP_CODE_MODEM   6'h00
`define UIP_CODE_FLOW    6'h10
`define UIP_CODE_CHG     6'h20
`define UIP_CODE_NONE    6'h01
`define UIP_TOUT_CHARS   8'h04
`define UIP_TOUT_BITS    8'h0C
`endif

// [uip_pkg.sv]
// Purpose: types of the uart interrupt prioritizer
// Assumes: constants come from the params header
// Notes:   level order follows reported priority
package uip_pkg;
   typedef enum {
      uip_lvl_none,
      uip_lvl_line,
      uip_lvl_tout,
      uip_lvl_receive_ready_source,
      uip_lvl_transmit_ready_source,
      uip_lvl_modem,
      uip_lvl_flow,
      uip_lvl_chg
   } uip_level_type;
   typedef logic [7:0] uip_byte_type;
endpackage : uip_pkg

// [uip_sticky.sv]
// Purpose: bank of sticky flags, set by events, cleared by accesses
// Assumes: set and clear come from logic on the same clock
// Notes:   a set in the clearing cycle wins, no event is lost
`timescale 1ns/100ps
module uip_sticky #(
   parameter int W = 1
) (
   input  wire logic         mclk_i,
   input  wire logic         resetn_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] set_i,
   input  wire logic [W-1:0] clr_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] q_d;

   // set beats clear
   assign q_d = set_i | (q_o & ~clr_i);

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         q_o <= '0;
      end else if (ce_i) begin
         q_o <= q_d;
      end
   end
endmodule : uip_sticky

// [uip_top.sv]
// Purpose: interrupt enable and prioritized status of a fifo uart
// Assumes: status inputs come from uart logic on mclk_i; cts and gpio
//          are pins and are synchronised here
// Notes:   read data appear one cycle after the read strobe
`include "uip_params.svh"
`timescale 1ns/100ps
module uip_top (
   input  wire logic                 mclk_i,
   input  wire logic                 resetn_i,
   input  wire logic                 ce_i,
   input  wire logic [3:0]           addr_i,
   input  wire uip_pkg::uip_byte_type wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output uip_pkg::uip_byte_type     rdata_o,
   output logic                      irq_o,
   input  wire logic                 rx_data_present_i,
   input  wire logic                 rx_at_trigger_i,
   input  wire logic                 rx_char_in_i,
   input  wire logic                 rhr_read_i,
   input  wire logic                 overrun_i,
   input  wire logic [2:0]           head_err_i,
   input  wire logic                 err_at_head_i,
   input  wire logic                 err_enter_i,
   input  wire logic                 fifo_err_i,
   input  wire logic                 thr_empty_i,
   input  wire logic                 tx_below_trigger_i,
   input  wire logic                 tx_all_empty_i,
   input  wire logic                 thr_write_i,
   input  wire logic                 bit_tick_i,
   input  wire logic [3:0]           char_bits_i,
   input  wire logic [3:0]           modem_delta_i,
   input  wire logic [3:0]           modem_lines_i,
   input  wire logic                 rts_level_i,
   input  wire logic                 cts_pin_i,
   input  wire logic                 xon_match_i,
   input  wire logic                 xoff_match_i,
   input  wire logic                 special_match_i,
   input  wire logic                 wakeup_i,
   input  wire logic [7:0]           gpio_pin_i,
   input  wire logic                 gpio_level_read_i
);
   import uip_pkg::*;

   uip_byte_type  ier_q, ctrl_q, gpol_q, gen_q, rdata_q;
   uip_byte_type  ier_d, isr_val, line_val, rd_mux;
   logic          irq_q;
   logic [1:0]    cts_sync_q;
   logic [15:0]   gpio_sync_q;
   logic          cts_prev_q, rts_prev_q, tx_cond_q;
   logic [7:0]    gpio_prev_q, tout_cnt_q, tout_cnt_d;
   logic [11:0]   flag_q;
   uip_level_type top_lvl;
   logic [5:0]    top_code;

   // decoded accesses
   wire rd_isr   = rd_i && (addr_i == `UIP_OFS_ISR);
   wire rd_line  = rd_i && (addr_i == `UIP_OFS_LINE);
   wire rd_modem = rd_i && (addr_i == `UIP_OFS_MODEM);
   wire wr_ier   = wr_i && (addr_i == `UIP_OFS_IER);
   wire wr_ctrl  = wr_i && (addr_i == `UIP_OFS_CTRL);
   wire wr_gpol  = wr_i && (addr_i == `UIP_OFS_GPOL);
   wire wr_gen   = wr_i && (addr_i == `UIP_OFS_GEN);

   // control bits
   wire fifo_en  = ctrl_q[`UIP_CTRL_FIFO];
   wire efr_en   = ctrl_q[`UIP_CTRL_EFR];
   wire auto_rts = ctrl_q[`UIP_CTRL_ARTS];
   wire auto_cts = ctrl_q[`UIP_CTRL_ACTS];
   wire err_in   = ctrl_q[`UIP_CTRL_ERRIN];
   wire wake_en  = ctrl_q[`UIP_CTRL_WAKE] && efr_en;

   // upper enables only take part with enhanced functions on
   wire [7:0] ier_eff = {ier_q[7:4] & {4{efr_en}}, ier_q[3:0]};

   // upper half only written with enhanced functions on
   assign ier_d = {efr_en ? wdata_i[7:4] : ier_q[7:4],
                   wdata_i[3:0]};

   // sticky flag indices
   localparam int F_LINE = 0;
   localparam int F_TOUT = 1;
   localparam int F_TX   = 2;
   localparam int F_MDM  = 3; // four bits, 3..6
   localparam int F_XON  = 7;
   localparam int F_XOFF = 8;
   localparam int F_SPC  = 9;
   localparam int F_CHG  = 10;
   localparam int F_WAKE = 11;
   logic gpio_pend_q;

   // pin synchronisers, first stage read only by the second
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         cts_sync_q  <= 2'h0;
         gpio_sync_q <= 16'h0000;
      end else if (ce_i) begin
         cts_sync_q  <= {cts_sync_q[0], cts_pin_i};
         gpio_sync_q <= {gpio_sync_q[7:0], gpio_pin_i};
      end
   end
   wire       cts_s  = cts_sync_q[1];
   wire [7:0] gpio_s = gpio_sync_q[15:8];

   // transmit ready condition per mode
   wire tx_cond = fifo_en ? tx_below_trigger_i : thr_empty_i;
   // gpio: enabled input asserted under chosen polarity
   wire [7:0] gpio_act = (gpio_s ^ gpol_q) & gen_q;
   // overrun memory, the overrun input is only a pulse
   logic ovr_q;

   // register writes and edge history
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         ier_q       <= `UIP_RST_BYTE;
         ctrl_q      <= `UIP_RST_BYTE;
         gpol_q      <= `UIP_RST_BYTE;
         gen_q       <= `UIP_RST_BYTE;
         cts_prev_q  <= 1'b0;
         rts_prev_q  <= 1'b0;
         tx_cond_q   <= 1'b0;
         gpio_prev_q <= 8'h00;
      end else if (ce_i) begin
         if (wr_ier)  ier_q  <= ier_d;
         if (wr_ctrl) ctrl_q <= wdata_i;
         if (wr_gpol) gpol_q <= wdata_i;
         if (wr_gen)  gen_q  <= wdata_i;
         cts_prev_q  <= cts_s;
         rts_prev_q  <= rts_level_i;
         tx_cond_q   <= tx_cond;
         gpio_prev_q <= gpio_act;
      end
   end

   // enabling with the holding register already empty also raises it
   wire tx_en_rise = wr_ier && ier_d[1] && !ier_q[1] && tx_cond;
   wire tx_set     = (tx_cond && !tx_cond_q) || tx_en_rise;

   // rx ready is a level, it drops as reads take fifo below trigger
   wire rx_ready = fifo_en ? rx_at_trigger_i : rx_data_present_i;

   // line status: overrun at once, char error at head or on entry
   wire line_set = overrun_i ||
                   (err_in ? err_enter_i : err_at_head_i);

   // time-out timer, restarted by each arrival or holding read
   wire [7:0] tout_limit = 8'(`UIP_TOUT_CHARS * {4'h0, char_bits_i})
                         + `UIP_TOUT_BITS;
   wire tout_hold = rx_char_in_i || rhr_read_i ||
                    !rx_data_present_i || !fifo_en;
   wire tout_fire = !tout_hold && bit_tick_i &&
                    (tout_cnt_q != tout_limit) &&
                    (8'(tout_cnt_q + 8'h01) == tout_limit);
   always_comb begin
      tout_cnt_d = tout_cnt_q;
      if (tout_hold) begin
         tout_cnt_d = 8'h00;
      end else if (bit_tick_i && tout_cnt_q != tout_limit) begin
         tout_cnt_d = 8'(tout_cnt_q + 8'h01);
      end
   end
   // timer count, frozen once it reaches the limit
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         tout_cnt_q <= 8'h00;
      end else if (ce_i) begin
         tout_cnt_q <= tout_cnt_d;
      end
   end

   // flow-control change edges
   wire rts_rise = auto_rts && rts_level_i && !rts_prev_q;
   wire cts_rise = auto_cts && cts_s && !cts_prev_q;

   wire       gpio_set = |(gpio_act & ~gpio_prev_q);

   // priority encoding of enabled pending sources
   wire p_line  = flag_q[F_LINE] && ier_eff[2];
   wire p_tout  = flag_q[F_TOUT] && ier_eff[0];
   wire p_receive_ready_source = rx_ready && ier_eff[0];
   wire p_tx    = flag_q[F_TX] && ier_eff[1];
   wire p_modem = (|flag_q[F_MDM+3:F_MDM]) && ier_eff[3];
   wire p_flow  = (|flag_q[F_SPC:F_XON]) && ier_eff[5];
   wire p_chg   = flag_q[F_CHG] && (ier_eff[6] || ier_eff[7]);
   wire p_wake  = flag_q[F_WAKE] && wake_en;
   wire any_lvl = p_line || p_tout || p_receive_ready_source || p_tx ||
                  p_modem || p_flow || p_chg;
   wire any_pend = any_lvl || p_wake || gpio_pend_q;

   // highest level wins, lower ones keep waiting
   always_comb begin
      top_lvl  = uip_lvl_none;
      top_code = `UIP_CODE_NONE;
      if (p_line) begin
         top_lvl  = uip_lvl_line;
         top_code = `UIP_CODE_LINE;
      end else if (p_tout) begin
         top_lvl  = uip_lvl_tout;
         top_code = `UIP_CODE_TOUT;
      end else if (p_receive_ready_source) begin
         top_lvl  = uip_lvl_receive_ready_source;
         top_code = `UIP_CODE_RECEIVE_READY_SOURCE;
      end else if (p_tx) begin
         top_lvl  = uip_lvl_transmit_ready_source;
         top_code = `UIP_CODE_TRANSMIT_READY_SOURCE;
      end else if (p_modem) begin
         top_lvl  = uip_lvl_modem;
         top_code = `UIP_CODE_MODEM;
      end else if (p_flow) begin
         top_lvl  = uip_lvl_flow;
         top_code = `UIP_CODE_FLOW;
      end else if (p_chg) begin
         top_lvl  = uip_lvl_chg;
         top_code = `UIP_CODE_CHG;
      end
   end

   // status byte: fifo flag, gpio flag relative to it, code
   assign isr_val = {fifo_en, fifo_en ^ gpio_pend_q, top_code};
   // line status for polled use, errors from the holding position
   assign line_val = {fifo_err_i, tx_all_empty_i, thr_empty_i,
                      head_err_i, ovr_q,
                      rx_data_present_i};

   // status read only clears what it reported
   wire isr_tx   = rd_isr && (top_lvl == uip_lvl_transmit_ready_source);
   wire isr_flow = rd_isr && (top_lvl == uip_lvl_flow);
   wire isr_wake = rd_isr && (top_lvl == uip_lvl_none);

   // one bit per sticky source
   wire [11:0] f_set = {wakeup_i, rts_rise || cts_rise,
                        special_match_i, xoff_match_i, xon_match_i,
                        modem_delta_i, tx_set, tout_fire, line_set};
   wire [11:0] f_clr = {isr_wake, rd_modem,
                        isr_flow || rx_char_in_i, isr_flow, isr_flow,
                        {4{rd_modem}}, isr_tx || thr_write_i,
                        rhr_read_i, rd_line};

   uip_sticky #(
      .W (12)
   ) u_flags (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .set_i    (f_set),
      .clr_i    (f_clr),
      .q_o      (flag_q)
   );

   uip_sticky #(
      .W (1)
   ) u_gpio (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .set_i    (gpio_set),
      .clr_i    (gpio_level_read_i),
      .q_o      (gpio_pend_q)
   );

   // overrun stays visible until line status is read
   uip_sticky #(
      .W (1)
   ) u_ovr (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .set_i    (overrun_i),
      .clr_i    (rd_line),
      .q_o      (ovr_q)
   );

   // read data select, unmapped offsets read zero
   assign rd_mux = (addr_i == `UIP_OFS_IER)   ? ier_q :
                   (addr_i == `UIP_OFS_ISR)   ? isr_val :
                   (addr_i == `UIP_OFS_CTRL)  ? ctrl_q :
                   (addr_i == `UIP_OFS_LINE)  ? line_val :
                   (addr_i == `UIP_OFS_MODEM) ?
                      {modem_lines_i, flag_q[F_MDM+3:F_MDM]} :
                   (addr_i == `UIP_OFS_GPOL)  ? gpol_q :
                   (addr_i == `UIP_OFS_GEN)   ? gen_q : 8'h00;

   // read data and interrupt line, both registered
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         rdata_q <= 8'h00;
         irq_q   <= 1'b0;
      end else if (ce_i) begin
         rdata_q <= rd_i ? rd_mux : 8'h00;
         irq_q   <= any_pend;
      end
   end
   assign rdata_o = rdata_q;
   assign irq_o   = irq_q;

   // ---- checks
   sequence cts_low_s;
      ce_i && !cts_s && auto_cts;
   endsequence
   sequence cts_high_s;
      ce_i && cts_s && auto_cts;
   endsequence

   idle_code_a: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) ce_i && rd_isr && !any_lvl
      |=> rdata_o[5:0] == 6'h01)
      else $error("idle status code wrong");

   line_top_a: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) ce_i && rd_isr && p_line
      |=> rdata_o[5:0] == 6'h06)
      else $error("line status not top priority");

   fifo_bits_a: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) ce_i && rd_isr
      |=> rdata_o[7] == $past(fifo_en) &&
          rdata_o[6] == ($past(fifo_en) ^ $past(gpio_pend_q)))
      else $error("status bits 7:6 wrong");

   line_clear_a: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) ce_i && rd_line && !line_set
      |=> !flag_q[F_LINE])
      else $error("line status not cleared");

   tx_enable_a: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) ce_i && wr_ier && wdata_i[1] && !ier_q[1] &&
      tx_cond |=> flag_q[F_TX] && ier_q[1])
      else $error("tx ready missed on enable");

   irq_follow_a: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) ce_i |=> irq_o == $past(any_pend))
      else $error("interrupt line wrong");

   tout_set_a: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) ce_i && tout_fire |=> flag_q[F_TOUT])
      else $error("time-out not raised");

   cts_edge_a: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) cts_low_s ##1 cts_high_s
      |=> flag_q[F_CHG])
      else $error("cts rise not caught");

   upper_gate_a: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) ce_i && wr_ier && !efr_en
      |=> $stable(ier_q[7:4]))
      else $error("upper enables written without enhanced");

   spc_clear_a: assert property (@(posedge mclk_i) disable iff
      (!resetn_i) ce_i && rx_char_in_i && !special_match_i
      |=> !flag_q[F_SPC])
      else $error("special match not cleared");
endmodule : uip_top

// [uip_host_model.sv]
// Purpose: host processor model on the plain register port
// Assumes: strobes change by non-blocking assignment after a rising edge
// Notes:   released address and data show inverted values, never stale
`timescale 1ns/100ps
module uip_host_model (
   input  wire logic             mclk_i,
   output logic [3:0]            addr_o,
   output uip_pkg::uip_byte_type wdata_o,
   output logic                  wr_o,
   output logic                  rd_o
);
   import uip_pkg::*;
   // idle bus at time zero
   initial begin
      addr_o  = 4'h0;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   // one-cycle write, then scramble so a late latch would be caught
   task automatic write_reg(input logic [3:0] a, input uip_byte_type d);
      @(posedge mclk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge mclk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
   endtask : write_reg
   // one-cycle read, data stand only in the following cycle
   task automatic read_reg(input logic [3:0] a);
      @(posedge mclk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge mclk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
   endtask : read_reg
endmodule : uip_host_model

// [uart_interrupt_prioritizer_test.sv]
// Purpose: self-checking bench of the interrupt prioritizer
// Assumes: host model drives the register port, bench drives uart status
// Notes:   expected reads queued by the driver, popped by a monitor
`timescale 1ns/100ps
module uart_interrupt_prioritizer_test;
   import uip_pkg::*;
   logic         mclk_i, resetn_i, wr, rd, irq, rd_seen;
   logic [3:0]   addr, mlines, cbits;
   uip_byte_type wdata, rdata, gpio;
   logic [15:0]  ev_q;
   logic         rxp, rxt, ferr, thr_e, txb, txa, rts, cts;
   logic [2:0]   head;
   int           errors, cmp_count, seed, i;
   uip_byte_type exp_q[$];
   // event bits: 0 arrival 1 rhr read 2 overrun 3 err head 4 err entry
   // 5 thr write 6 bit tick 7 xon 8 xoff 9 special 10 wake 11 gpio read
   uip_top dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .irq_o(irq), .rx_data_present_i(rxp),
      .rx_at_trigger_i(rxt), .rx_char_in_i(ev_q[0]),
      .rhr_read_i(ev_q[1]), .overrun_i(ev_q[2]), .head_err_i(head),
      .err_at_head_i(ev_q[3]), .err_enter_i(ev_q[4]), .fifo_err_i(ferr),
      .thr_empty_i(thr_e), .tx_below_trigger_i(txb),
      .tx_all_empty_i(txa), .thr_write_i(ev_q[5]), .bit_tick_i(ev_q[6]),
      .char_bits_i(cbits), .modem_delta_i(ev_q[15:12]),
      .modem_lines_i(mlines), .rts_level_i(rts), .cts_pin_i(cts),
      .xon_match_i(ev_q[7]), .xoff_match_i(ev_q[8]),
      .special_match_i(ev_q[9]), .wakeup_i(ev_q[10]), .gpio_pin_i(gpio),
      .gpio_level_read_i(ev_q[11]));
   uip_host_model host_u (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd));
   // free-running 40 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   task automatic ck(input uip_byte_type s, input uip_byte_type e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : ck
   task automatic print_verdict;
      if (errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   task automatic wr_r(input logic [3:0] a, input uip_byte_type d);
      host_u.write_reg(a, d);
   endtask : wr_r
   // the driver notes the expected byte before the read goes out
   task automatic rd_r(input logic [3:0] a, input uip_byte_type e);
      exp_q.push_back(e);
      host_u.read_reg(a);
   endtask : rd_r
   task automatic pl(input int n);
      @(posedge mclk_i);
      ev_q[n] <= 1'b1;
      @(posedge mclk_i);
      ev_q[n] <= 1'b0;
   endtask : pl
   // irq is registered, so give the flag and the output one edge each
   task automatic ci(input logic e);
      repeat (2) @(posedge mclk_i);
      #1 ck({7'h00, irq}, {7'h00, e});
   endtask : ci
   // pins pass a two-flop synchroniser, so wait bounded for the output
   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 20) begin
         @(posedge mclk_i);
         n++;
      end
      if (irq !== 1'b1) begin
         errors++;
         print_verdict();
      end
   endtask : wait_irq
   // read data stand only in the cycle after the strobe
   always @(posedge mclk_i) rd_seen <= rd;
   always @(negedge mclk_i) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) errors++;
         else ck(rdata, exp_q.pop_front());
      end
   end
   initial begin
      seed = 32'h690d62de;
      errors = 0;
      cmp_count = 0;
      resetn_i = 1'b0;
      rd_seen = 1'b0;
      ev_q = 16'h0000;
      {rxp, rxt, ferr, thr_e, txb, txa, rts, cts} = 8'h00;
      head = 3'h0;
      cbits = 4'hA;
      gpio = 8'h00;
      mlines = 4'h0;
      repeat (12) @(posedge mclk_i);
      resetn_i <= 1'b1;
      mlines <= 4'($random(seed));
      // reset values, unmapped place reads zero
      rd_r(4'h1, 8'h00);
      rd_r(4'h2, 8'h01);
      rd_r(4'h4, 8'h00);
      ci(1'b0);
      // upper enables only take with enhanced functions on
      wr_r(4'h1, 8'hFF);
      rd_r(4'h1, 8'h0F);
      wr_r(4'h3, 8'h02);
      wr_r(4'h1, 8'hFF);
      rd_r(4'h1, 8'hFF);
      wr_r(4'h1, 8'h00);
      // line status fields with random levels
      for (i = 0; i < 4; i++) begin
         @(posedge mclk_i);
         {ferr, txa, thr_e, head, rxp} <= 7'($random(seed));
         @(posedge mclk_i);
         rd_r(4'h5, {ferr, txa, thr_e, head, 1'b0, rxp});
      end
      {ferr, txa, thr_e, head, rxp} <= 7'h00;
      // three sources at once, reported one at a time by level
      wr_r(4'h1, 8'h0E);
      @(posedge mclk_i);
      thr_e <= 1'b1;
      pl(3);
      pl(12);
      rd_r(4'h2, 8'h06);
      rd_r(4'h2, 8'h06);
      rd_r(4'h5, 8'h20);
      rd_r(4'h2, 8'h02);
      rd_r(4'h2, 8'h00);
      rd_r(4'h6, {mlines, 4'h1});
      rd_r(4'h2, 8'h01);
      ci(1'b0);
      // tx cleared by a holding write, raised at once on enable
      @(posedge mclk_i);
      thr_e <= 1'b0;
      @(posedge mclk_i);
      thr_e <= 1'b1;
      ci(1'b1);
      pl(5);
      rd_r(4'h2, 8'h01);
      wr_r(4'h1, 8'h00);
      wr_r(4'h1, 8'h02);
      rd_r(4'h2, 8'h02);
      rd_r(4'h2, 8'h01);
      wr_r(4'h1, 8'h04);
      thr_e <= 1'b0;
      // error on entry counts only in the entry mode
      pl(4);
      rd_r(4'h2, 8'h01);
      wr_r(4'h3, 8'h12);
      pl(4);
      rd_r(4'h2, 8'h06);
      rd_r(4'h5, 8'h00);
      pl(2);
      ci(1'b1);
      rd_r(4'h2, 8'h06);
      rd_r(4'h5, 8'h02);
      rd_r(4'h2, 8'h01);
      // xon, xoff, special, each cleared by the status read
      wr_r(4'h3, 8'h02);
      wr_r(4'h1, 8'h20);
      for (i = 7; i < 10; i++) begin
         pl(i);
         rd_r(4'h2, 8'h10);
         rd_r(4'h2, 8'h01);
      end
      pl(9);
      pl(0);
      rd_r(4'h2, 8'h01);
      // rts rising edge, then cts pin rising edge
      wr_r(4'h3, 8'h06);
      wr_r(4'h1, 8'h40);
      rts <= 1'b1;
      rd_r(4'h2, 8'h20);
      rd_r(4'h2, 8'h20);
      rd_r(4'h6, {mlines, 4'h0});
      rts <= 1'b0;
      rd_r(4'h2, 8'h01);
      wr_r(4'h3, 8'h0A);
      wr_r(4'h1, 8'h80);
      cts <= 1'b1;
      wait_irq();
      rd_r(4'h2, 8'h20);
      rd_r(4'h6, {mlines, 4'h0});
      rd_r(4'h2, 8'h01);
      // rx ready without fifo, then polled mode and trigger with fifo
      wr_r(4'h3, 8'h00);
      wr_r(4'h1, 8'h01);
      rxp <= 1'b1;
      rd_r(4'h2, 8'h04);
      wr_r(4'h1, 8'h00);
      wr_r(4'h3, 8'h01);
      rd_r(4'h5, 8'h01);
      ci(1'b0);
      wr_r(4'h1, 8'h01);
      rxt <= 1'b1;
      rd_r(4'h2, 8'hC4);
      rxt <= 1'b0;
      rd_r(4'h2, 8'hC1);
      // time-out at four ten-bit chars plus twelve bits
      repeat (4 * 10 + 12 - 1) pl(6);
      rd_r(4'h2, 8'hC1);
      pl(6);
      rd_r(4'h2, 8'hCC);
      pl(1);
      rd_r(4'h2, 8'hC1);
      rxp <= 1'b0;
      // gpio, plain and inverted polarity
      wr_r(4'h3, 8'h00);
      wr_r(4'h1, 8'h00);
      wr_r(4'h8, 8'h01);
      gpio <= 8'h01;
      wait_irq();
      rd_r(4'h2, 8'h41);
      pl(11);
      ci(1'b0);
      gpio <= 8'h03;
      wr_r(4'h7, 8'h02);
      wr_r(4'h8, 8'h02);
      gpio <= 8'h01;
      wait_irq();
      rd_r(4'h2, 8'h41);
      pl(11);
      rd_r(4'h2, 8'h01);
      // wake-up shares the no-pending code
      wr_r(4'h3, 8'h22);
      pl(10);
      ci(1'b1);
      rd_r(4'h2, 8'h01);
      ci(1'b0);
      repeat (3) @(posedge mclk_i);
      if (exp_q.size() != 0) errors++;
      print_verdict();
   end
endmodule : uart_interrupt_prioritizer_test
